// *** verilog/spc_regs.svh ***
// register offsets, reset values and frame constants of the serial control port
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH

// register offsets (16-bit register address space)
`define SPC_OFS_EXPECTED_CRC_LOW   16'h0084
`define SPC_OFS_EXPECTED_CRC_HIGH  16'h0085
`define SPC_OFS_MAP_CRC_ENABLE     16'h0086
`define SPC_OFS_MAP_CRC_READY      16'h0087
`define SPC_OFS_MAP_CRC_VALUE_LOW  16'h0088
`define SPC_OFS_MAP_CRC_VALUE_HIGH 16'h0089
`define SPC_OFS_FRAME_CRC_DISABLE  16'hFD00

// reset values
`define SPC_RST_MAP_CRC_ENABLE     16'h0001
`define SPC_RST_FRAME_CRC_DISABLE  16'h0000

// value that turns frame crc off when written to the disable register
`define SPC_FRAME_CRC_OFF          16'h0001

// frame crc: x^16+x^15+x^12+x^7+x^6+x^4+x^3+1, shifted msb first
`define SPC_CRC_POLY               16'h90D9
`define SPC_CRC_INIT               16'h0000

// frame layout
`define SPC_LAST_HEAD_BIT          4'h7
`define SPC_LAST_WORD_BIT          4'hF
`define SPC_CRC_READ_WORDS         3'h3
`define SPC_HEAD_ZERO_MSB          7
`define SPC_HEAD_ZERO_LSB          2
`define SPC_HEAD_ADDR_BIT          1
`define SPC_HEAD_RNW_BIT           0

`endif

// *** verilog/spc_pkg.sv ***
// types shared by the serial control port
package spc_pkg;

  // frame sequencer states, one-hot
  typedef enum logic [4:0]
  {
    SPC_IDLE = 5'b00001,
    SPC_HEAD = 5'b00010,
    SPC_ADDR = 5'b00100,
    SPC_DATA = 5'b01000,
    SPC_SKIP = 5'b10000
  } spc_state_t;

  // one register write travelling to the register file
  typedef struct packed
  {
    logic [15:0] addr;
    logic [15:0] data;
  } spc_wr_t;

endpackage

// *** verilog/spc_control_port.sv ***
// slave serial control port with frame crc and register map crc
`timescale 1ns/100ps
`include "spc_regs.svh"

module spc_control_port
  import spc_pkg::*;
#(
  parameter int REG_WORDS = 256
)
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic serial_clock_in,
  input  wire logic slave_select_n_in,
  input  wire logic host_to_device_line_in,
  output logic      device_to_host_line_out,
  output logic      device_to_host_line_oe_out,
  input  wire logic device_address_select_pin_in,
  input  wire logic master_clock_running_in
);

  localparam int IDX_W = $clog2(REG_WORDS);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [2:0]  sclk_sync;
  logic [2:0]  ss_sync;
  logic [1:0]  mosi_sync;
  logic [1:0]  mclk_sync;
  logic [1:0]  strap_sync;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        ss_active;
  logic        ss_end;
  logic        mosi_bit;
  logic        mclk_ok;

  // every pin passes two flops; edge detection only looks at later stages
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sclk_sync  <= 3'h7;
      ss_sync    <= 3'h7;
      mosi_sync  <= 2'h0;
      mclk_sync  <= 2'h0;
      strap_sync <= 2'h0;
    end
    else
    begin
      sclk_sync  <= {sclk_sync[1:0], serial_clock_in};
      ss_sync    <= {ss_sync[1:0], slave_select_n_in};
      mosi_sync  <= {mosi_sync[0], host_to_device_line_in};
      mclk_sync  <= {mclk_sync[0], master_clock_running_in};
      strap_sync <= {strap_sync[0], device_address_select_pin_in};
    end
  end

  // mode 3: clock idles high, sample on rise, drive on fall
  assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
  assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
  assign ss_active = ~ss_sync[1];
  assign ss_end    = ss_sync[1] & ~ss_sync[2];
  assign mosi_bit  = mosi_sync[1];
  assign mclk_ok   = mclk_sync[1];

  // ----------------------------------------------------------------
  // address strap, caught once the synchroniser has filled
  // ----------------------------------------------------------------
  logic [1:0] strap_wait;
  logic       strap_level;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      strap_wait  <= 2'h0;
      strap_level <= 1'b0;
    end
    else if (strap_wait != 2'h3)
    begin
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == 2'h2)
        strap_level <= strap_sync[1];
    end
  end

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  spc_state_t  state;
  logic [3:0]  bit_cnt;
  logic [2:0]  word_cnt;
  logic        rnw;
  logic [15:0] rx_sh;
  logic [15:0] rx_word;
  logic [15:0] base_addr;
  logic [15:0] last_word;
  logic [15:0] word_buf [0:2];
  logic [15:0] crc;
  logic [15:0] crc_mark;
  logic [15:0] crc_last_start;
  logic [15:0] crc_next;
  logic        crc_bit;
  logic        crc_en;
  logic        word_end;
  logic [15:0] frame_crc_disable;

  assign rx_word  = {rx_sh[14:0], mosi_bit};
  assign word_end = sclk_rise && ss_active && (state == SPC_DATA) && (bit_cnt == `SPC_LAST_WORD_BIT);
  assign crc_en   = (frame_crc_disable != `SPC_FRAME_CRC_OFF);

  // crc runs over address and data only; reads fold in the bits sent
  assign crc_bit  = ((state == SPC_DATA) && rnw) ? device_to_host_line_out : mosi_bit;
  assign crc_next = {crc[14:0], 1'b0} ^ ((crc[15] ^ crc_bit) ? `SPC_CRC_POLY : 16'h0000);

  // header, address and data phases, counted on sampled rising edges
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state          <= SPC_IDLE;
      bit_cnt        <= 4'h0;
      word_cnt       <= 3'h0;
      rnw            <= 1'b0;
      rx_sh          <= 16'h0000;
      base_addr      <= 16'h0000;
      last_word      <= 16'h0000;
      crc            <= `SPC_CRC_INIT;
      crc_mark       <= `SPC_CRC_INIT;
      crc_last_start <= `SPC_CRC_INIT;
      word_buf[0]    <= 16'h0000;
      word_buf[1]    <= 16'h0000;
      word_buf[2]    <= 16'h0000;
    end
    else if (!ss_active)
    begin
      state    <= SPC_IDLE;
      bit_cnt  <= 4'h0;
      word_cnt <= 3'h0;
    end
    else if (sclk_rise)
    begin
      rx_sh   <= rx_word;
      bit_cnt <= bit_cnt + 4'h1;
      unique case (state)
        SPC_IDLE, SPC_HEAD:
        begin
          state <= SPC_HEAD;
          if (bit_cnt == `SPC_LAST_HEAD_BIT)
          begin
            bit_cnt <= 4'h0;
            crc     <= `SPC_CRC_INIT;
            rnw     <= rx_word[`SPC_HEAD_RNW_BIT];
            // foreign address or nonzero pad bits: sit out the frame
            if ((rx_word[`SPC_HEAD_ZERO_MSB:`SPC_HEAD_ZERO_LSB] == 6'h00) &&
                (rx_word[`SPC_HEAD_ADDR_BIT] == strap_level))
              state <= SPC_ADDR;
            else
              state <= SPC_SKIP;
          end
        end
        SPC_ADDR:
        begin
          crc <= crc_next;
          if (bit_cnt == `SPC_LAST_WORD_BIT)
          begin
            base_addr <= rx_word;
            crc_mark  <= crc_next;
            state     <= SPC_DATA;
          end
        end
        SPC_DATA:
        begin
          crc <= crc_next;
          if (bit_cnt == `SPC_LAST_WORD_BIT)
          begin
            last_word      <= rx_word;
            crc_mark       <= crc_next;
            crc_last_start <= crc_mark;
            if (word_cnt != 3'h7)
              word_cnt <= word_cnt + 3'h1;
            if (word_cnt < 3'h3)
              word_buf[word_cnt[1:0]] <= rx_word;
          end
        end
        SPC_SKIP:
        begin
          bit_cnt <= 4'h0;
        end
        default:
        begin
          state <= SPC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // crc-checked write commit and expected crc capture
  // ----------------------------------------------------------------
  logic        frame_whole;
  logic        crc_good;
  logic        crc_bad;
  logic [1:0]  commit_left;
  logic [1:0]  commit_idx;
  logic [15:0] expected_crc;

  // a crc write ends on a word boundary with one to three data words
  assign frame_whole = ss_end && (state == SPC_DATA) && !rnw && crc_en && (bit_cnt == 4'h0) &&
                       (word_cnt >= 3'h2) && (word_cnt <= 3'h4);
  assign crc_good    = frame_whole && (last_word == crc_last_start);
  assign crc_bad     = frame_whole && (last_word != crc_last_start);

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      commit_left  <= 2'h0;
      commit_idx   <= 2'h0;
      expected_crc <= 16'h0000;
    end
    else if (crc_good)
    begin
      commit_left <= 2'(word_cnt - 3'h1);
      commit_idx  <= 2'h0;
    end
    else if (crc_bad)
    begin
      expected_crc <= crc_last_start;
    end
    else if (commit_left != 2'h0)
    begin
      commit_left <= commit_left - 2'h1;
      commit_idx  <= commit_idx + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // write requests: immediate without crc, from buffer with crc
  // ----------------------------------------------------------------
  logic    wr_req;
  spc_wr_t wr;
  logic    wr_fire;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_req <= 1'b0;
      wr     <= '0;
    end
    else if (word_end && !rnw && !crc_en)
    begin
      wr_req  <= 1'b1;
      wr.addr <= base_addr + 16'(word_cnt);
      wr.data <= rx_word;
    end
    else if (commit_left != 2'h0)
    begin
      wr_req  <= 1'b1;
      wr.addr <= base_addr + 16'(commit_idx);
      wr.data <= word_buf[commit_idx];
    end
    else
    begin
      wr_req <= 1'b0;
    end
  end

  assign wr_fire = wr_req && mclk_ok;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [15:0] regs [0:REG_WORDS-1];
  logic [15:0] map_crc_enable;

  // plain storage array; every address below REG_WORDS is written, read-only offsets included
  always_ff @(posedge clk_in)
  begin
    if (wr_fire && (wr.addr < 16'(REG_WORDS)))
      regs[wr.addr[IDX_W-1:0]] <= wr.data;
  end

  // control registers with defined reset values
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      map_crc_enable    <= `SPC_RST_MAP_CRC_ENABLE;
      frame_crc_disable <= `SPC_RST_FRAME_CRC_DISABLE;
    end
    else if (wr_fire)
    begin
      if (wr.addr == `SPC_OFS_MAP_CRC_ENABLE)
        map_crc_enable <= wr.data;
      if (wr.addr == `SPC_OFS_FRAME_CRC_DISABLE)
        frame_crc_disable <= wr.data;
    end
  end

  // ----------------------------------------------------------------
  // register map crc engine, one word per cycle
  // ----------------------------------------------------------------
  logic [IDX_W-1:0] map_idx;
  logic [15:0]      map_acc;
  logic [15:0]      map_value;
  logic             map_crc_ready;

  function automatic logic [15:0] crc_word(input logic [15:0] acc, input logic [15:0] w);
    logic [15:0] c;
    c = acc;
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? `SPC_CRC_POLY : 16'h0000);
    return c;
  endfunction

  // any write restarts the sweep so the result never goes stale
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      map_idx       <= '0;
      map_acc       <= `SPC_CRC_INIT;
      map_value     <= 16'h0000;
      map_crc_ready <= 1'b0;
    end
    else if (wr_fire || !map_crc_enable[0])
    begin
      map_idx       <= '0;
      map_acc       <= `SPC_CRC_INIT;
      map_crc_ready <= 1'b0;
    end
    else if (!map_crc_ready)
    begin
      map_acc <= crc_word(map_acc, regs[map_idx]);
      map_idx <= map_idx + 1'b1;
      if (map_idx == IDX_W'(REG_WORDS - 1))
      begin
        map_value     <= crc_word(map_acc, regs[map_idx]);
        map_crc_ready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [15:0] rd_addr;
  logic [15:0] rd_value;
  logic [15:0] next_tx;
  logic [15:0] tx_sh;

  // byte registers sit in the low byte, upper bits read zero
  always_comb
  begin
    rd_addr = (state == SPC_ADDR) ? rx_word : base_addr + 16'(word_cnt) + 16'h0001;
    rd_value = 16'h0000;
    if (mclk_ok)
    begin
      if (rd_addr == `SPC_OFS_EXPECTED_CRC_LOW)
        rd_value = {8'h00, expected_crc[7:0]};
      else if (rd_addr == `SPC_OFS_EXPECTED_CRC_HIGH)
        rd_value = {8'h00, expected_crc[15:8]};
      else if (rd_addr == `SPC_OFS_MAP_CRC_ENABLE)
        rd_value = map_crc_enable;
      else if (rd_addr == `SPC_OFS_MAP_CRC_READY)
        rd_value = {15'h0000, map_crc_ready};
      else if (rd_addr == `SPC_OFS_MAP_CRC_VALUE_LOW)
        rd_value = {8'h00, map_value[7:0]};
      else if (rd_addr == `SPC_OFS_MAP_CRC_VALUE_HIGH)
        rd_value = {8'h00, map_value[15:8]};
      else if (rd_addr == `SPC_OFS_FRAME_CRC_DISABLE)
        rd_value = frame_crc_disable;
      else if (rd_addr < 16'(REG_WORDS))
        rd_value = regs[rd_addr[IDX_W-1:0]];
    end
    // with crc on, three words are followed by the crc, then zeros
    if (crc_en && (state == SPC_DATA) && (word_cnt == 3'h2))
      next_tx = crc_next;
    else if (crc_en && (state == SPC_DATA) && (word_cnt >= `SPC_CRC_READ_WORDS))
      next_tx = 16'h0000;
    else
      next_tx = rd_value;
  end

  // load on the rise ending a word, shift on each fall of a read's data phase
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      tx_sh <= 16'h0000;
    else if (sclk_rise && ss_active && (bit_cnt == `SPC_LAST_WORD_BIT) &&
             ((state == SPC_ADDR) || (state == SPC_DATA)))
      tx_sh <= next_tx;
    else if (sclk_fall && (state == SPC_DATA) && rnw)
      tx_sh <= {tx_sh[14:0], 1'b0};
  end

  // line is driven only through the data phase of an accepted read
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      device_to_host_line_out    <= 1'b0;
      device_to_host_line_oe_out <= 1'b0;
    end
    else if (!ss_active || (state != SPC_DATA) || !rnw)
    begin
      device_to_host_line_out    <= 1'b0;
      device_to_host_line_oe_out <= 1'b0;
    end
    else if (sclk_fall)
    begin
      device_to_host_line_out    <= tx_sh[15];
      device_to_host_line_oe_out <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_oe_read_only;
    @(posedge clk_in) disable iff (rst_in)
    // enable is registered, so it answers to the conditions one cycle back
    device_to_host_line_oe_out |-> $past(state == SPC_DATA) && $past(rnw) && $past(ss_active);
  endproperty
  a_oe_read_only: assert property (p_oe_read_only) else $error("line driven outside a read");

  property p_oe_starts_byte3;
    @(posedge clk_in) disable iff (rst_in)
    $rose(device_to_host_line_oe_out) |-> (word_cnt == 3'h0) && (bit_cnt == 4'h0) && $past(sclk_fall);
  endproperty
  a_oe_starts_byte3: assert property (p_oe_starts_byte3) else $error("read drive not at first data bit");

  property p_foreign_skipped;
    @(posedge clk_in) disable iff (rst_in)
    (sclk_rise && ss_active && (state == SPC_HEAD) && (bit_cnt == `SPC_LAST_HEAD_BIT) &&
     (rx_word[`SPC_HEAD_ADDR_BIT] != strap_level)) |=> (state == SPC_SKIP);
  endproperty
  a_foreign_skipped: assert property (p_foreign_skipped) else $error("frame for other address accepted");

  property p_no_clock_no_write;
    @(posedge clk_in) disable iff (rst_in)
    !mclk_ok |=> $stable(map_crc_enable) && $stable(frame_crc_disable);
  endproperty
  a_no_clock_no_write: assert property (p_no_clock_no_write) else $error("write without master clock");

  property p_crc_off;
    @(posedge clk_in) disable iff (rst_in)
    (wr_fire && (wr.addr == `SPC_OFS_FRAME_CRC_DISABLE) && (wr.data == `SPC_FRAME_CRC_OFF)) |=> !crc_en;
  endproperty
  a_crc_off: assert property (p_crc_off) else $error("crc not disabled");

  property p_bad_crc_discard;
    @(posedge clk_in) disable iff (rst_in)
    crc_bad |=> (commit_left == 2'h0) ##1 !wr_req [*3];
  endproperty
  a_bad_crc_discard: assert property (p_bad_crc_discard) else $error("bad crc write committed");

  property p_bad_crc_kept;
    @(posedge clk_in) disable iff (rst_in)
    crc_bad |=> (expected_crc == $past(crc_last_start));
  endproperty
  a_bad_crc_kept: assert property (p_bad_crc_kept) else $error("expected crc not stored");

  property p_partial_dropped;
    @(posedge clk_in) disable iff (rst_in)
    (ss_end && (state == SPC_DATA) && (bit_cnt != 4'h0) && (commit_left == 2'h0)) |=> !wr_req [*2];
  endproperty
  a_partial_dropped: assert property (p_partial_dropped) else $error("partial frame wrote");

  property p_next_address;
    @(posedge clk_in) disable iff (rst_in)
    (wr_req && (commit_left != 2'h0)) |=> !wr_req || (wr.addr == $past(wr.addr) + 16'h0001);
  endproperty
  a_next_address: assert property (p_next_address) else $error("burst address not consecutive");

  property p_map_ready_enabled;
    @(posedge clk_in) disable iff (rst_in)
    $rose(map_crc_ready) |-> map_crc_enable[0] && $past(map_crc_enable[0]);
  endproperty
  a_map_ready_enabled: assert property (p_map_ready_enabled) else $error("map crc ready while disabled");

  c_plain_write: cover property (@(posedge clk_in) disable iff (rst_in) wr_fire && !crc_en);
  c_crc_write:   cover property (@(posedge clk_in) disable iff (rst_in) crc_good);
  c_crc_bad:     cover property (@(posedge clk_in) disable iff (rst_in) crc_bad);
  c_read_drive:  cover property (@(posedge clk_in) disable iff (rst_in) $rose(device_to_host_line_oe_out));
  c_map_ready:   cover property (@(posedge clk_in) disable iff (rst_in) $rose(map_crc_ready));

endmodule

// *** verification/spc_host_model.sv ***
// host master model that frames transfers on the serial control port
`timescale 1ns/100ps
module spc_host_model
(
  output logic        sclk_out,
  output logic        ssn_out,
  output logic        mosi_out,
  input  wire logic   miso_in,
  output logic        res_stb_out,
  output logic [15:0] res_out
);
  logic [15:0] w;

  // idle: clock high, select high
  initial
  begin
    sclk_out = 1'b1;
    ssn_out = 1'b1;
    mosi_out = 1'b0;
    res_stb_out = 1'b0;
    res_out = 16'h0000;
    w = 16'h0000;
  end

  //----------------------------------------
  // one frame
  //----------------------------------------
  // header, nt words out, nrx words in; lim cuts the frame short
  task automatic run(input logic [7:0] hdr, input logic [15:0] tx [8], input int nt, input int nrx, input int lim);
    int nb;
    nb = 8 + 16 * nt;
    // called on clock edges, but each bit takes 799 or 800 ns, not whole periods: non-blocking keeps pins off the race
    ssn_out <= 1'b0;
    #400;
    for (int i = 0; i < nb + 16 * nrx && i < lim; i++)
    begin
      sclk_out <= 1'b0;
      #100;
      // read phase drives a changing filler, never a stale bit
      mosi_out <= i < 8 ? hdr[7 - i] : i < nb ? tx[(i - 8) / 16][15 - (i - 8) % 16] : ~mosi_out;
      #400;
      sclk_out <= 1'b1;
      w = {w[14:0], miso_in};
      if (i >= nb && (i - nb) % 16 == 15)
      begin
        res_out = w;
        res_stb_out = 1'b1;
        #1;
        res_stb_out = 1'b0;
      end
      #299;
    end
    ssn_out <= 1'b1;
    mosi_out <= ~mosi_out;
    #1600;
  endtask
endmodule

// *** verification/spc_control_port_tb_top.sv ***
// self-checking bench of the serial control port
`timescale 1ns/100ps
`include "spc_regs.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module spc_control_port_tb_top;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        strap = 1'b1;
  logic        mclk = 1'b1;
  logic        crc_on = 1'b1;
  logic        sclk, ssn, mosi, miso_d, miso_oe, res_stb;
  logic [15:0] res, ev, last_crc, bc;
  logic [15:0] tx [8];
  logic [15:0] wd [3];
  logic [15:0] good [3];
  logic [15:0] exp_q [$];
  int          fails = 0;
  int          total_checks = 0;
  int          hi = 0;
  wire         miso = miso_oe ? miso_d : 1'bz;

  always #50 clk_in = ~clk_in;

  spc_control_port #(.REG_WORDS(64)) DUT (.clk_in(clk_in), .rst_in(rst_in), .serial_clock_in(sclk),
    .slave_select_n_in(ssn), .host_to_device_line_in(mosi), .device_to_host_line_out(miso_d),
    .device_to_host_line_oe_out(miso_oe), .device_address_select_pin_in(strap),
    .master_clock_running_in(mclk));

  spc_host_model host (.sclk_out(sclk), .ssn_out(ssn), .mosi_out(mosi), .miso_in(miso),
    .res_stb_out(res_stb), .res_out(res));

  //----------------------------------------
  // helpers
  //----------------------------------------
  function automatic logic [15:0] crc_w(input logic [15:0] c, input logic [15:0] d);
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `SPC_CRC_POLY : 16'h0000);
    return c;
  endfunction

  // write n words of wd from a; bad spoils the crc
  task automatic wr(input logic [15:0] a, input int n, input logic bad, input int lim = 999);
    logic [15:0] c;
    c = crc_w(`SPC_CRC_INIT, a);
    tx[0] = a;
    for (int i = 0; i < n; i++)
    begin
      tx[i + 1] = wd[i];
      c = crc_w(c, wd[i]);
    end
    tx[n + 1] = c ^ {15'h0000, bad};
    last_crc = c;
    host.run({6'h00, strap, 1'b0}, tx, n + 1 + int'(crc_on), 0, lim);
  endtask

  // read at a; a nonzero hdr is a foreign header, so the line must float
  task automatic rd(input logic [15:0] a, input logic [15:0] e [3], input logic [7:0] hdr = 8'h00);
    logic [15:0] c;
    c = crc_w(`SPC_CRC_INIT, a);
    for (int i = 0; i < (crc_on ? 3 : 1); i++)
    begin
      exp_q.push_back(hdr != 8'h00 ? 16'hZZZZ : e[i]);
      c = crc_w(c, e[i]);
    end
    if (crc_on)
      exp_q.push_back(hdr != 8'h00 ? 16'hZZZZ : c);
    tx[0] = a;
    host.run(hdr != 8'h00 ? hdr : {6'h00, strap, 1'b1}, tx, 1, crc_on ? 4 : 1, 999);
  endtask

  task automatic stop_test();
    if (exp_q.size() != 0)
      fails++;
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  //----------------------------------------
  // checking
  //----------------------------------------
  // each word the host receives against the oldest note
  always @(posedge res_stb)
  begin
    ev = exp_q.pop_front();
    `CHK(res, ev)
  end

  // line released once select has been high a while
  always @(posedge clk_in)
  begin
    hi <= ssn ? hi + 1 : 0;
    if (hi > 5)
      `CHK(miso_oe, 1'b0)
  end

  // watchdog well beyond the expected run of about 1.1 ms
  initial
  begin
    #3000000;
    fails++;
    stop_test();
  end

  //----------------------------------------
  // scenarios
  //----------------------------------------
  initial
  begin
    void'($urandom(32'hCAE3));
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    rd(`SPC_OFS_EXPECTED_CRC_LOW, '{16'h0000, 16'h0000, `SPC_RST_MAP_CRC_ENABLE});
    for (int i = 0; i < 3; i++)
      wd[i] = 16'($urandom);
    wr(16'h0010, 3, 1'b0);
    good = wd;
    rd(16'h0010, good);
    wd[0] = ~good[0];
    wr(16'h0010, 1, 1'b1);
    bc = last_crc;
    wr(`SPC_OFS_EXPECTED_CRC_HIGH, 1, 1'b0);
    rd(`SPC_OFS_EXPECTED_CRC_LOW, '{{8'h00, bc[7:0]}, {8'h00, bc[15:8]}, 16'h0001});
    rd(16'h0010, good);
    rd(16'h0010, good, {6'h00, ~strap, 1'b1});
    rd(16'h0010, good, 8'h07);
    wd[0] = `SPC_FRAME_CRC_OFF;
    wr(`SPC_OFS_FRAME_CRC_DISABLE, 1, 1'b0);
    crc_on = 1'b0;
    rd(`SPC_OFS_FRAME_CRC_DISABLE, '{`SPC_FRAME_CRC_OFF, 16'h0000, 16'h0000});
    wd[0] = 16'($urandom);
    wd[1] = 16'($urandom);
    wr(16'h0030, 2, 1'b0);
    good = wd;
    rd(16'h0031, '{good[1], 16'h0000, 16'h0000});
    wd[0] = ~good[0];
    wr(16'h0030, 1, 1'b0, 32);
    rd(16'h0030, good);
    @(posedge clk_in);
    mclk <= 1'b0;
    wr(16'h0030, 1, 1'b0);
    rd(16'h0030, '{16'h0000, 16'h0000, 16'h0000});
    @(posedge clk_in);
    mclk <= 1'b1;
    rd(16'h0030, good);
    rd(16'h0100, '{16'h0000, 16'h0000, 16'h0000});
    wd[0] = 16'h0000;
    wr(`SPC_OFS_MAP_CRC_ENABLE, 1, 1'b0);
    rd(`SPC_OFS_MAP_CRC_READY, '{16'h0000, 16'h0000, 16'h0000});
    wd[0] = `SPC_RST_MAP_CRC_ENABLE;
    wr(`SPC_OFS_MAP_CRC_ENABLE, 1, 1'b0);
    rd(`SPC_OFS_MAP_CRC_READY, '{16'h0001, 16'h0000, 16'h0000});
    stop_test();
  end
endmodule
